// ---- testbench/srr_host_model.sv ----
// host side model: issues decoded commands and keeps the output queue
`timescale 1ns/100ps
`default_nettype none

module srr_host_model
(
    input wire logic clk,
    input wire logic cmdReady,
    input wire logic rspValid,
    input wire logic [7:0] rspData,
    input wire logic queueFlush,
    output var logic cmdValid,
    output var srr_pkg::srr_cmd_t cmdCode,
    output var logic [7:0] cmdData,
    output var logic queueHasMessage
);
    import srr_pkg::*;

    int flushCount = 0;

    initial
    begin
        cmdValid = 1'b0;
        cmdCode = CMD_CLS;
        cmdData = 8'h00;
        queueHasMessage = 1'b0;
    end

    // -------------------------------------------------------------------
    // output queue
    // -------------------------------------------------------------------
    always @(negedge clk)
    begin
        if (queueFlush === 1'b1)
        begin
            queueHasMessage <= 1'b0;
            flushCount <= flushCount + 1;
        end
    end

    task automatic post_message();
        @(negedge clk);
        queueHasMessage = 1'b1;
    endtask

    // -------------------------------------------------------------------
    // command issue, held until taken
    // -------------------------------------------------------------------
    task automatic issue(input srr_cmd_t code, input logic [7:0] data,
        input logic wantRsp, output logic [7:0] rsp, output logic got,
        output logic hung);
        int n;
        n = 0;
        @(negedge clk);
        cmdValid = 1'b1;
        cmdCode = code;
        cmdData = data;
        while (cmdReady !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        hung = (n >= 100);
        n = 0;
        @(negedge clk);
        // released lines carry junk so a stale value is never reused
        cmdValid = 1'b0;
        cmdCode = srr_cmd_t'(~code);
        cmdData = ~data;
        while (wantRsp && rspValid !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        got = (rspValid === 1'b1);
        rsp = rspData;
        hung = hung || (n >= 100);
    endtask
endmodule // srr_host_model

`default_nettype wire

// ---- testbench/srr_status_core_tb_top.sv ----
// self-checking bench for the status reporting core
`timescale 1ns/100ps
`default_nettype none

module srr_status_core_tb_top;
    import srr_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic opsPending = 1'b0;
    logic [3:0] fault = 4'h0;
    logic [3:0] errEv = 4'h0;
    logic cmdValid, cmdReady, rspValid, queueFlush;
    logic serviceRequest, queueHasMessage, got, hung;
    srr_cmd_t cmdCode;
    logic [7:0] cmdData, rspData, rsp, exp8;
    int fails = 0;
    int nTests = 0;

    always #25 clk = ~clk;

    srr_status_core u_srr_status_core (
        .clk(clk), .rst_n(rst_n),
        .alarmActive(fault[3]), .heaterFault(fault[2]),
        .sensorFaultFirstInput(fault[0]), .sensorFaultSecondInput(fault[1]),
        .queryErrorEvent(errEv[3]), .deviceErrorEvent(errEv[2]),
        .executionErrorEvent(errEv[1]), .commandErrorEvent(errEv[0]),
        .opsPending(opsPending), .queueHasMessage(queueHasMessage),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
        .queueFlush(queueFlush), .serviceRequest(serviceRequest));

    srr_host_model u_srr_host_model (
        .clk(clk), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspData(rspData), .queueFlush(queueFlush), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdData(cmdData),
        .queueHasMessage(queueHasMessage));

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        nTests++;
        if (act !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, act, exp);
        end
    endtask

    task automatic cmd(input srr_cmd_t code, input logic [7:0] data,
        input logic wantRsp);
        u_srr_host_model.issue(code, data, wantRsp, rsp, got, hung);
        if (hung)
        begin
            fails++;
            final_report();
        end
        chk({7'h00, got}, {7'h00, wantRsp});
    endtask

    task automatic rd(input srr_cmd_t code, input logic [7:0] exp);
        cmd(code, 8'h00, 1'b1);
        chk(rsp, exp);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle error event, index 0 is the command error
    task automatic pulse(input int i);
        @(negedge clk);
        errEv[i] = 1'b1;
        @(negedge clk);
        errEv[i] = 1'b0;
    endtask

    // -------------------------------------------------------------------
    // sequence
    // -------------------------------------------------------------------
    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(CMD_ESR_RD, 8'h01);
        rd(CMD_ESR_RD, 8'h00);
        rd(CMD_ESE_RD, 8'h00);
        rd(CMD_SRE_RD, 8'h00);
        rd(CMD_FAULT_EN_RD, 8'h00);
        rd(CMD_STB_RD, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            fault = (i < 4) ? (4'h1 << i) : 4'hf;
            exp8 = {fault[3], 2'h0, fault[2], 2'h0, fault[1:0]};
            waitc(2);
            rd(CMD_FAULT_RD, exp8);
        end
        fault = 4'h8;
        cmd(CMD_FAULT_EN_WR, 8'hff, 1'b0);
        rd(CMD_FAULT_EN_RD, 8'h93);
        cmd(CMD_FAULT_EN_WR, 8'h10, 1'b0);
        rd(CMD_STB_RD, 8'h00);
        fault = 4'h4;
        waitc(2);
        rd(CMD_STB_RD, 8'h08);
        cmd(CMD_SRE_WR, 8'hff, 1'b0);
        rd(CMD_SRE_RD, 8'h38);
        chk({7'h00, serviceRequest}, 8'h01);
        rd(CMD_STB_RD, 8'h48);
        cmd(CMD_SRE_WR, 8'h10, 1'b0);
        waitc(2);
        chk({7'h00, serviceRequest}, 8'h00);
        fault = 4'h0;
        // latched events survive several idle cycles
        for (int i = 0; i < 4; i++)
        begin
            pulse(i);
            waitc(4);
            exp8 = 8'h04 << i;
            rd(CMD_ESR_RD, exp8);
        end
        cmd(CMD_ESE_WR, 8'hff, 1'b0);
        rd(CMD_ESE_RD, 8'hbd);
        cmd(CMD_SRE_WR, 8'h20, 1'b0);
        pulse(2);
        waitc(2);
        rd(CMD_STB_RD, 8'h60);
        rd(CMD_ESR_RD, 8'h10);
        waitc(2);
        chk({7'h00, serviceRequest}, 8'h00);
        cmd(srr_cmd_t'(4'hc), 8'h00, 1'b0);
        rd(CMD_ESR_RD, 8'h04);
        u_srr_host_model.post_message();
        waitc(2);
        rd(CMD_STB_RD, 8'h10);
        pulse(1);
        cmd(CMD_CLS, 8'h00, 1'b0);
        waitc(3);
        chk(8'(u_srr_host_model.flushCount), 8'h01);
        rd(CMD_STB_RD, 8'h00);
        rd(CMD_ESR_RD, 8'h00);
        opsPending = 1'b1;
        cmd(CMD_OPC, 8'h00, 1'b0);
        waitc(5);
        rd(CMD_ESR_RD, 8'h00);
        opsPending = 1'b0;
        waitc(3);
        rd(CMD_ESR_RD, 8'h80);
        opsPending = 1'b1;
        fork
            rd(CMD_OPC_RD, 8'h31);
            begin
                waitc(4);
                chk({7'h00, cmdReady}, 8'h00);
                opsPending = 1'b0;
            end
        join
        // nothing pending: the query answers at once
        rd(CMD_OPC_RD, 8'h31);
        final_report();
    end
endmodule // srr_status_core_tb_top

`default_nettype wire

// ---- verilog/srr_flag_latch.sv ----
// sticky flag bank: set wins over clear
`timescale 1ns/100ps
`default_nettype none

module srr_flag_latch
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clearBits,
    output logic [WIDTH-1:0] flags
);

    if (WIDTH < 1)
    begin : g_widthCheck
        $error("srr_flag_latch: WIDTH must be positive");
    end

    wire logic [WIDTH-1:0] next_flags;

    // an event in the clearing cycle survives
    assign next_flags = (flags & ~clearBits) | setBits;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= RESET_VAL;
        else
            flags <= next_flags;
    end

endmodule // srr_flag_latch

`default_nettype wire

// ---- verilog/srr_pkg.sv ----
// constants and types shared by the status reporting registers
`default_nettype none

package srr_pkg;

    // -------------------------------------------------------------------
    // register widths
    // -------------------------------------------------------------------
    localparam int STATUS_W = 8;

    // -------------------------------------------------------------------
    // instrument fault status bit positions
    // -------------------------------------------------------------------
    localparam int IFS_ALARM_BIT = 7;
    localparam int IFS_HEATER_BIT = 4;
    localparam int IFS_SENSOR_B_BIT = 1;
    localparam int IFS_SENSOR_A_BIT = 0;
    localparam logic [7:0] IFS_DEFINED = 8'h93;

    // -------------------------------------------------------------------
    // standard event flag bit positions
    // -------------------------------------------------------------------
    localparam int SEF_OPC_BIT = 7;
    localparam int SEF_QUERY_ERR_BIT = 5;
    localparam int SEF_DEVICE_ERR_BIT = 4;
    localparam int SEF_EXEC_ERR_BIT = 3;
    localparam int SEF_CMD_ERR_BIT = 2;
    localparam int SEF_POWER_BIT = 0;
    localparam logic [7:0] SEF_DEFINED = 8'hbd;
    localparam logic [7:0] SEF_RESET = 8'h01;

    // -------------------------------------------------------------------
    // summary status byte bit positions
    // -------------------------------------------------------------------
    localparam int SSB_RQS_BIT = 6;
    localparam int SSB_STD_EVENT_BIT = 5;
    localparam int SSB_MAV_BIT = 4;
    localparam int SSB_INST_EVENT_BIT = 3;
    localparam logic [7:0] SRM_DEFINED = 8'h38;

    // -------------------------------------------------------------------
    // mask reset values and reply codes
    // -------------------------------------------------------------------
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] OPC_REPLY = 8'h31;

    // -------------------------------------------------------------------
    // decoded host commands
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_CLS = 4'h0,
        CMD_ESE_WR = 4'h1,
        CMD_ESE_RD = 4'h2,
        CMD_ESR_RD = 4'h3,
        CMD_OPC = 4'h4,
        CMD_OPC_RD = 4'h5,
        CMD_SRE_WR = 4'h6,
        CMD_SRE_RD = 4'h7,
        CMD_STB_RD = 4'h8,
        CMD_FAULT_RD = 4'h9,
        CMD_FAULT_EN_WR = 4'ha,
        CMD_FAULT_EN_RD = 4'hb
    } srr_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_OPC_WAIT = 2'b10
    } srr_state_t;

endpackage

`default_nettype wire

// ---- verilog/srr_status_core.sv ----
// status reporting registers with command port and service request
//
// Notes on behaviour
// - instrument fault status bit 7 follows any asserted alarm
// - instrument fault status bit 4 follows a heater fault
// - bit 0 flags input A sensor fault, bit 1 input B
// - host reads instrument fault status with the fault status query
// - fault enable mask has the same layout, ANDed bit for bit
// - status byte bit 3 is OR of fault status AND its mask
// - standard event bit 7 marks operation complete
// - standard event bit 5 set on a query syntax error
// - standard event bit 4 set on a device error
// - standard event bit 3 set when a valid command cannot execute
// - standard event bit 2 set on a command syntax error
// - standard event bit 0 shows power is on
// - status byte bit 5 is OR of event flags AND event mask
// - status byte bit 4 set while output queue holds a message
// - status byte bit 6 reports a request for service
// - service request is OR of status byte AND request mask
// - clear-status empties event flags, output queue and message bit
// - operation-complete command sets bit 7 once nothing is pending
`timescale 1ns/100ps
`default_nettype none

module srr_status_core
#(
    parameter int WIDTH = srr_pkg::STATUS_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    // fault levels from the instrument
    input wire logic alarmActive,
    input wire logic heaterFault,
    input wire logic sensorFaultFirstInput,
    input wire logic sensorFaultSecondInput,
    // one-cycle error events from the command parser
    input wire logic queryErrorEvent,
    input wire logic deviceErrorEvent,
    input wire logic executionErrorEvent,
    input wire logic commandErrorEvent,
    // level: some device operation still running
    input wire logic opsPending,
    // level: output queue is not empty
    input wire logic queueHasMessage,
    // decoded command port
    input wire logic cmdValid,
    input wire srr_pkg::srr_cmd_t cmdCode,
    input wire logic [WIDTH-1:0] cmdData,
    output logic cmdReady,
    output logic rspValid,
    output logic [WIDTH-1:0] rspData,
    // tells the queue logic to flush on clear-status
    output logic queueFlush,
    output logic serviceRequest
);

    import srr_pkg::*;

    if (WIDTH != STATUS_W)
    begin : g_widthCheck
        $error("srr_status_core: WIDTH must equal STATUS_W");
    end

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    srr_state_t state, next_state;
    logic [WIDTH-1:0] instrument_fault_status;
    logic [WIDTH-1:0] instrument_fault_enable;
    logic [WIDTH-1:0] standard_event_flags;
    logic [WIDTH-1:0] standard_event_mask;
    logic [WIDTH-1:0] service_request_mask;
    logic message_available_flag;
    logic opcArmed;

    // -------------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------------
    wire logic cmdTake;
    wire logic doCls, doEseWr, doEseRd, doEsrRd, doOpc, doOpcRd;
    wire logic doSreWr, doSreRd, doStbRd, doFaultRd, doFaultEnWr;
    wire logic doFaultEnRd, doUnknown;

    // no new command while an opc query waits for the device
    assign cmdReady = (state == ST_IDLE);
    assign cmdTake = cmdValid & cmdReady;
    assign doCls = cmdTake & (cmdCode == CMD_CLS);
    assign doEseWr = cmdTake & (cmdCode == CMD_ESE_WR);
    assign doEseRd = cmdTake & (cmdCode == CMD_ESE_RD);
    assign doEsrRd = cmdTake & (cmdCode == CMD_ESR_RD);
    assign doOpc = cmdTake & (cmdCode == CMD_OPC);
    assign doOpcRd = cmdTake & (cmdCode == CMD_OPC_RD);
    assign doSreWr = cmdTake & (cmdCode == CMD_SRE_WR);
    assign doSreRd = cmdTake & (cmdCode == CMD_SRE_RD);
    assign doStbRd = cmdTake & (cmdCode == CMD_STB_RD);
    assign doFaultRd = cmdTake & (cmdCode == CMD_FAULT_RD);
    assign doFaultEnWr = cmdTake & (cmdCode == CMD_FAULT_EN_WR);
    assign doFaultEnRd = cmdTake & (cmdCode == CMD_FAULT_EN_RD);
    // an undecodable code is a command syntax error
    assign doUnknown = cmdTake & ~(doCls | doEseWr | doEseRd | doEsrRd
        | doOpc | doOpcRd | doSreWr | doSreRd | doStbRd | doFaultRd
        | doFaultEnWr | doFaultEnRd);

    // -------------------------------------------------------------------
    // instrument fault status
    // -------------------------------------------------------------------
    wire logic [WIDTH-1:0] next_faultStatus;

    assign next_faultStatus = {alarmActive, 2'b00, heaterFault, 2'b00,
        sensorFaultSecondInput, sensorFaultFirstInput};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            instrument_fault_status <= '0;
        else
            instrument_fault_status <= next_faultStatus;
    end

    // -------------------------------------------------------------------
    // mask registers, undefined bits forced to zero
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instrument_fault_enable <= MASK_RESET;
            standard_event_mask <= MASK_RESET;
            service_request_mask <= MASK_RESET;
        end
        else
        begin
            if (doFaultEnWr)
                instrument_fault_enable <= cmdData & IFS_DEFINED;
            if (doEseWr)
                standard_event_mask <= cmdData & SEF_DEFINED;
            if (doSreWr)
                service_request_mask <= cmdData & SRM_DEFINED;
        end
    end

    // -------------------------------------------------------------------
    // standard event flags
    // -------------------------------------------------------------------
    wire logic opcDone;
    wire logic [WIDTH-1:0] eventSet, eventClear;

    assign opcDone = opcArmed & ~opsPending;
    assign eventSet = {opcDone, 1'b0, queryErrorEvent, deviceErrorEvent,
        executionErrorEvent, commandErrorEvent | doUnknown, 2'b00};
    // a flags read clears after the value is captured for the reply
    assign eventClear = (doCls | doEsrRd) ? '1 : '0;

    // power bit comes from reset and stays until cleared
    srr_flag_latch #(
        .WIDTH(WIDTH),
        .RESET_VAL(SEF_RESET)
    ) u_eventFlags (
        .clk(clk),
        .rst_n(rst_n),
        .setBits(eventSet),
        .clearBits(eventClear),
        .flags(standard_event_flags)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            opcArmed <= 1'b0;
        else if (doOpc)
            opcArmed <= 1'b1;
        else if (opcDone | doCls)
            opcArmed <= 1'b0;
    end

    // -------------------------------------------------------------------
    // status byte and service request
    // -------------------------------------------------------------------
    wire logic instrument_event_summary, standard_event_summary;
    wire logic service_request_flag;
    wire logic [WIDTH-1:0] stbBase, summary_status_byte;

    assign instrument_event_summary =
        |(instrument_fault_status & instrument_fault_enable);
    assign standard_event_summary =
        |(standard_event_flags & standard_event_mask);
    assign stbBase = {2'b00, standard_event_summary, message_available_flag,
        instrument_event_summary, 3'b000};
    assign service_request_flag = |(stbBase & service_request_mask);
    assign summary_status_byte = stbBase
        | ({{(WIDTH-1){1'b0}}, service_request_flag} << SSB_RQS_BIT);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            serviceRequest <= 1'b0;
        else
            serviceRequest <= service_request_flag;
    end

    // -------------------------------------------------------------------
    // message available and queue flush
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            message_available_flag <= 1'b0;
            queueFlush <= 1'b0;
        end
        else
        begin
            // queue level lags the flush by a cycle, so hold off once more
            message_available_flag <= queueHasMessage & ~doCls
                & ~queueFlush;
            queueFlush <= doCls;
        end
    end

    // -------------------------------------------------------------------
    // reply path and opc query wait
    // -------------------------------------------------------------------
    logic next_rspValid;
    logic [WIDTH-1:0] next_rspData;

    always_comb
    begin
        next_state = state;
        next_rspValid = 1'b0;
        next_rspData = rspData;
        case (state)
            ST_IDLE:
            begin
                next_rspValid = doEseRd | doEsrRd | doSreRd | doStbRd
                    | doFaultRd | doFaultEnRd | (doOpcRd & ~opsPending);
                if (doEseRd)
                    next_rspData = standard_event_mask;
                else if (doEsrRd)
                    next_rspData = standard_event_flags;
                else if (doSreRd)
                    next_rspData = service_request_mask;
                else if (doStbRd)
                    next_rspData = summary_status_byte;
                else if (doFaultRd)
                    next_rspData = instrument_fault_status;
                else if (doFaultEnRd)
                    next_rspData = instrument_fault_enable;
                else if (doOpcRd)
                    next_rspData = OPC_REPLY;
                if (doOpcRd & opsPending)
                    next_state = ST_OPC_WAIT;
            end
            ST_OPC_WAIT:
            begin
                if (!opsPending)
                begin
                    next_rspValid = 1'b1;
                    next_rspData = OPC_REPLY;
                    next_state = ST_IDLE;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            rspValid <= 1'b0;
            rspData <= '0;
        end
        else
        begin
            state <= next_state;
            rspValid <= next_rspValid;
            rspData <= next_rspData;
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_opcArm;
        doOpc ##1 opcArmed;
    endsequence
    sequence s_opcFinish;
        opcArmed && !opsPending;
    endsequence

    a_alarm_bit_follows:
        assert property (alarmActive |=> instrument_fault_status[7])
        else $error("alarm bit not set after alarm");

    a_heater_bit_follows:
        assert property (##1 instrument_fault_status[4] == $past(heaterFault))
        else $error("heater bit does not track heater fault");

    a_sensor_bits_map:
        assert property (##1 instrument_fault_status[1:0]
            == {$past(sensorFaultSecondInput), $past(sensorFaultFirstInput)})
        else $error("sensor fault bits misplaced");

    a_fault_query_reply:
        assert property (doFaultRd |=> rspValid
            && rspData == $past(instrument_fault_status))
        else $error("fault status query reply wrong");

    a_inst_event_summary:
        assert property (summary_status_byte[3] == |(instrument_fault_status
            & instrument_fault_enable))
        else $error("instrument event summary wrong");
    a_std_event_summary:
        assert property (summary_status_byte[5] == |(standard_event_flags
            & standard_event_mask))
        else $error("standard event summary wrong");

    a_query_error_set:
        assert property (queryErrorEvent |=> standard_event_flags[5])
        else $error("query error flag not set");
    a_exec_error_set:
        assert property (executionErrorEvent |=> standard_event_flags[3])
        else $error("execution error flag not set");

    a_mav_tracks_queue:
        assert property (queueHasMessage && !doCls && !queueFlush
            |=> summary_status_byte[4])
        else $error("message available not shown");

    a_srq_from_mask:
        assert property (##1 serviceRequest
            == $past(|(stbBase & service_request_mask)))
        else $error("service request does not follow masked byte");

    a_cls_clears_all:
        assert property (doCls && eventSet == '0
            |=> standard_event_flags == '0 && !message_available_flag
            ##1 !message_available_flag)
        else $error("clear-status left status set");

    a_opc_completes:
        assert property (s_opcArm ##[0:1000] s_opcFinish
            |=> standard_event_flags[7])
        else $error("operation complete not flagged");

    a_undefined_zero:
        assert property ((standard_event_flags & ~SEF_DEFINED) == '0
            && (instrument_fault_enable & ~IFS_DEFINED) == '0
            && (service_request_mask & ~SRM_DEFINED) == '0)
        else $error("undefined bit reads nonzero");

    a_flag_stays_latched:
        assert property (standard_event_flags[2] && !doCls && !doEsrRd
            |=> standard_event_flags[2])
        else $error("command error flag dropped");

endmodule // srr_status_core

`default_nettype wire
